// ### hw/asr_bank.sv
/*
  asr_bank: shadowed register bank for a dual-channel converter.
  Assumes requests arrive as one-cycle byte accesses from a serial
  front end on clk; read data returns the next cycle.
*/
// How it works
// - setup writes 0x08-0x18 land in shadow only
// - writing 0x01 to 0xFF requests commit
// - commit copies all shadow values at once
// - commit bit clears itself after update
// - local registers kept per channel
// - channel select bits steer local access
// - both bits set writes both channels
// - both bits set reads channel A
// - global registers ignore channel select
`timescale 1ns/1ps
module asr_bank #(
  parameter logic [7:0] PART_ID = 8'h5a,   // arbitrary value
  parameter logic [1:0] SPEED_ID = 2'h0    // arbitrary value
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register access
  input asr_pkg::asr_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // port configuration
  output logic lsb_first,
  output logic soft_reset,
  // active settings
  output asr_pkg::asr_glb_cfg_t act_glb,
  output asr_pkg::asr_chan_cfg_t act_cha,
  output asr_pkg::asr_chan_cfg_t act_chb
);

  // ****************************************
  // decode
  // ****************************************
  function automatic logic hit(input asr_pkg::asr_req_t r, input logic [7:0] off);
    hit = r.wr && (r.addr == off);
  endfunction

  logic [1:0] chan_sel_r;
  logic commit_r;
  logic lsb_first_r;
  logic soft_reset_r;
  asr_pkg::asr_glb_cfg_t shd_glb_r;
  asr_pkg::asr_chan_cfg_t shd_ch_r [2];
  logic commit_wr;
  logic [1:0] wr_ch;

  assign commit_wr = hit(req, asr_pkg::ASR_OFF_COMMIT) && (req.wdata == asr_pkg::ASR_COMMIT_CODE);
  assign wr_ch = chan_sel_r;
  assign lsb_first = lsb_first_r;
  assign soft_reset = soft_reset_r;

  // ****************************************
  // port configuration and channel select
  // ****************************************
  // soft reset is a one-cycle strobe; it returns the shadows and channel select to defaults
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lsb_first_r <= 1'b0;
      soft_reset_r <= 1'b0;
    end else begin
      soft_reset_r <= 1'b0;
      if (hit(req, asr_pkg::ASR_OFF_PORT_CFG)) begin
        lsb_first_r <= req.wdata[asr_pkg::ASR_BIT_LSB_LO] | req.wdata[asr_pkg::ASR_BIT_LSB_HI];
        soft_reset_r <= req.wdata[asr_pkg::ASR_BIT_SRST_LO] | req.wdata[asr_pkg::ASR_BIT_SRST_HI];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_sel_r <= asr_pkg::ASR_RST_CHAN_SEL;
    end else if (soft_reset_r) begin
      chan_sel_r <= asr_pkg::ASR_RST_CHAN_SEL;
    end else if (hit(req, asr_pkg::ASR_OFF_CHAN_SEL)) begin
      chan_sel_r <= {req.wdata[asr_pkg::ASR_BIT_CHAN_B], req.wdata[asr_pkg::ASR_BIT_CHAN_A]};
    end
  end

  // ****************************************
  // shadow stage
  // ****************************************
  // global shadow, no channel steering
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shd_glb_r <= '{asr_pkg::ASR_RST_PDWN_FUNC, asr_pkg::ASR_RST_DCS, asr_pkg::ASR_RST_DIVIDER};
    end else if (soft_reset_r) begin
      shd_glb_r <= '{asr_pkg::ASR_RST_PDWN_FUNC, asr_pkg::ASR_RST_DCS, asr_pkg::ASR_RST_DIVIDER};
    end else if (hit(req, asr_pkg::ASR_OFF_POWER)) begin
      shd_glb_r.pdwn_func <= req.wdata[asr_pkg::ASR_BIT_PDWN_FUNC];
    end else if (hit(req, asr_pkg::ASR_OFF_DCS)) begin
      shd_glb_r.dcs_en <= req.wdata[0];
    end else if (hit(req, asr_pkg::ASR_OFF_DIVIDER)) begin
      shd_glb_r.divider <= req.wdata[2:0];
    end
  end

  // one local copy per channel, both written when both selected
  for (genvar c = 0; c < 2; c++) begin : g_chan
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        shd_ch_r[c] <= '{asr_pkg::ASR_RST_POWER_MODE, asr_pkg::ASR_RST_PATTERN};
      end else if (soft_reset_r) begin
        shd_ch_r[c] <= '{asr_pkg::ASR_RST_POWER_MODE, asr_pkg::ASR_RST_PATTERN};
      end else if (wr_ch[c] && hit(req, asr_pkg::ASR_OFF_POWER)) begin
        shd_ch_r[c].power_mode <= req.wdata[1:0];
      end else if (wr_ch[c] && hit(req, asr_pkg::ASR_OFF_PATTERN)) begin
        shd_ch_r[c].pattern <= {req.wdata[5:4], 1'b0, req.wdata[2:0]};
      end
    end
  end

  // ****************************************
  // commit
  // ****************************************
  // self-clearing commit bit, a new request wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      commit_r <= 1'b0;
    end else begin
      commit_r <= commit_wr;
    end
  end

  // every active setting loads on the same edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      act_glb <= '{asr_pkg::ASR_RST_PDWN_FUNC, asr_pkg::ASR_RST_DCS, asr_pkg::ASR_RST_DIVIDER};
      act_cha <= '{asr_pkg::ASR_RST_POWER_MODE, asr_pkg::ASR_RST_PATTERN};
      act_chb <= '{asr_pkg::ASR_RST_POWER_MODE, asr_pkg::ASR_RST_PATTERN};
    end else if (commit_r) begin
      act_glb <= shd_glb_r;
      act_cha <= shd_ch_r[0];
      act_chb <= shd_ch_r[1];
    end
  end

  // ****************************************
  // readback
  // ****************************************
  logic [7:0] rd_mux;
  asr_pkg::asr_chan_cfg_t rd_ch;

  // channel A wins when both are selected; reads show shadow values
  always_comb begin
    rd_ch = chan_sel_r[asr_pkg::ASR_BIT_CHAN_A] ? shd_ch_r[0] : shd_ch_r[1];
    rd_mux = 8'h00;  // unmapped addresses read zero
    unique case (req.addr)
      asr_pkg::ASR_OFF_PORT_CFG: begin
        rd_mux = asr_pkg::ASR_RST_PORT_CFG;
        rd_mux[asr_pkg::ASR_BIT_LSB_LO] = lsb_first_r;
        rd_mux[asr_pkg::ASR_BIT_LSB_HI] = lsb_first_r;
      end
      asr_pkg::ASR_OFF_PART_ID: rd_mux = PART_ID;
      asr_pkg::ASR_OFF_SPEED: rd_mux = {2'h0, SPEED_ID, 4'h0};
      asr_pkg::ASR_OFF_CHAN_SEL: rd_mux = {6'h00, chan_sel_r};
      asr_pkg::ASR_OFF_POWER: rd_mux = {2'h0, shd_glb_r.pdwn_func, 3'h0, rd_ch.power_mode};
      asr_pkg::ASR_OFF_DCS: rd_mux = {7'h00, shd_glb_r.dcs_en};
      asr_pkg::ASR_OFF_DIVIDER: rd_mux = {5'h00, shd_glb_r.divider};
      asr_pkg::ASR_OFF_PATTERN: rd_mux = {2'h0, rd_ch.pattern};
      asr_pkg::ASR_OFF_COMMIT: rd_mux = {7'h00, commit_r};
      default: rd_mux = 8'h00;
    endcase
  end

  // read data is held until the next read
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        rdata <= rd_mux;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  AST_SHADOW_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !commit_r |=> $stable(act_glb) && $stable(act_cha) && $stable(act_chb))
    else $error("active setting changed without commit");
  AST_COMMIT_REQ: assert property (@(posedge clk) disable iff (!rst_b)
    commit_wr |=> commit_r)
    else $error("commit write not recognised");
  AST_COMMIT_COPY: assert property (@(posedge clk) disable iff (!rst_b)
    commit_r |=> act_glb == $past(shd_glb_r) && act_cha == $past(shd_ch_r[0])
      && act_chb == $past(shd_ch_r[1]))
    else $error("commit did not copy all shadows");
  AST_COMMIT_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    commit_r && !commit_wr |=> !commit_r)
    else $error("commit bit did not clear");
  AST_LOCAL_A_ONLY: assert property (@(posedge clk) disable iff (!rst_b)
    hit(req, asr_pkg::ASR_OFF_PATTERN) && chan_sel_r == 2'h1 && !soft_reset_r
      |=> $stable(shd_ch_r[1]) && shd_ch_r[0].pattern[2:0] == $past(req.wdata[2:0]))
    else $error("local write misrouted");
  AST_LOCAL_BOTH: assert property (@(posedge clk) disable iff (!rst_b)
    hit(req, asr_pkg::ASR_OFF_PATTERN) && chan_sel_r == 2'h3 && !soft_reset_r
      |=> shd_ch_r[0].pattern == shd_ch_r[1].pattern)
    else $error("broadcast write missed a channel");
  AST_READ_A: assert property (@(posedge clk) disable iff (!rst_b)
    req.rd && req.addr == asr_pkg::ASR_OFF_PATTERN && chan_sel_r == 2'h3
      |=> rvalid && rdata[2:0] == $past(shd_ch_r[0].pattern[2:0]))
    else $error("dual-select read not from channel A");
  AST_GLOBAL_SHARED: assert property (@(posedge clk) disable iff (!rst_b)
    hit(req, asr_pkg::ASR_OFF_DIVIDER) && chan_sel_r == 2'h0 && !soft_reset_r
      |=> shd_glb_r.divider == $past(req.wdata[2:0]))
    else $error("global write blocked by channel select");
  AST_MIRROR: assert property (@(posedge clk) disable iff (!rst_b)
    hit(req, asr_pkg::ASR_OFF_PORT_CFG) && req.wdata[asr_pkg::ASR_BIT_LSB_LO]
      && !req.wdata[asr_pkg::ASR_BIT_LSB_HI] |=> lsb_first)
    else $error("low nibble bit order ignored");

endmodule // asr_bank

// ### include/asr_pkg.sv
/*
  asr_pkg: register offsets, reset values, field positions and carrier
  types for the converter's serial-port register bank.
  Assumes a serial front end that turns host frames into byte accesses.
*/
package asr_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ASR_OFF_PORT_CFG = 8'h00;
  localparam logic [7:0] ASR_OFF_PART_ID = 8'h01;
  localparam logic [7:0] ASR_OFF_SPEED = 8'h02;
  localparam logic [7:0] ASR_OFF_CHAN_SEL = 8'h05;
  localparam logic [7:0] ASR_OFF_POWER = 8'h08;
  localparam logic [7:0] ASR_OFF_DCS = 8'h09;
  localparam logic [7:0] ASR_OFF_DIVIDER = 8'h0b;
  localparam logic [7:0] ASR_OFF_PATTERN = 8'h0d;
  localparam logic [7:0] ASR_OFF_COMMIT = 8'hff;
  localparam logic [7:0] ASR_SHADOW_LO = 8'h08;
  localparam logic [7:0] ASR_SHADOW_HI = 8'h18;

  // ****************************************
  // reset values and command codes
  // ****************************************
  localparam logic [7:0] ASR_RST_PORT_CFG = 8'h18;
  localparam logic [1:0] ASR_RST_CHAN_SEL = 2'h3;
  localparam logic [1:0] ASR_RST_POWER_MODE = 2'h0;
  localparam logic ASR_RST_PDWN_FUNC = 1'h0;
  localparam logic ASR_RST_DCS = 1'h1;
  localparam logic [2:0] ASR_RST_DIVIDER = 3'h0;
  localparam logic [5:0] ASR_RST_PATTERN = 6'h00;
  localparam logic [7:0] ASR_COMMIT_CODE = 8'h01;

  // ****************************************
  // field positions
  // ****************************************
  localparam int ASR_BIT_CHAN_A = 0;
  localparam int ASR_BIT_CHAN_B = 1;
  localparam int ASR_BIT_LSB_LO = 1;
  localparam int ASR_BIT_LSB_HI = 6;
  localparam int ASR_BIT_SRST_LO = 2;
  localparam int ASR_BIT_SRST_HI = 5;
  localparam int ASR_BIT_PDWN_FUNC = 5;
  localparam int ASR_BIT_COMMIT = 0;

  // ****************************************
  // carrier types
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asr_req_t;

  typedef struct packed {
    logic [1:0] power_mode;
    logic [5:0] pattern;
  } asr_chan_cfg_t;

  typedef struct packed {
    logic pdwn_func;
    logic dcs_en;
    logic [2:0] divider;
  } asr_glb_cfg_t;

endpackage

// ### tb/asr_host_model.sv
/*
  asr_host_model: host side of the register bank, one byte access per task.
  Assumes the bench supplies clk and calls the tasks hierarchically.
*/
`timescale 1ns/1ps
module asr_host_model (
  // clock
  input wire logic clk,
  // request and answer
  output asr_pkg::asr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial req = '0;
  // released fields go inverted so stale values never pass for live ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 req = {1'b1, 1'b0, a, d};
    @(posedge clk);
    #1 req = {1'b0, 1'b0, ~a, ~d};
  endtask
  // channel select write before a local access
  task automatic sel(input logic [7:0] s);
    wr(8'h05, s);
  endtask
  task automatic commit();
    wr(8'hff, 8'h01);
  endtask
  // read strobe, answer taken one edge later
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1 req = {1'b0, 1'b1, a, ~a};
    @(posedge clk);
    #1 req.rd = 1'b0;
    v = rvalid;
    d = rdata;
  endtask
endmodule // asr_host_model

// ### tb/tb_adc_spi_shadow_register_bank.sv
/*
  tb_adc_spi_shadow_register_bank: bench with a behavioural register model.
  Assumes the bank answers reads one cycle late and commits two after.
*/
`timescale 1ns/1ps
module tb_adc_spi_shadow_register_bank;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  asr_pkg::asr_req_t req;
  logic [7:0] rdata;
  logic rvalid, lsb_first, soft_reset;
  asr_pkg::asr_glb_cfg_t act_glb;
  asr_pkg::asr_chan_cfg_t act_cha, act_chb;
  int err_count = 0;
  int samples_checked = 0;
  int seed = 6;
  int r, lsb, m_sel, m_div, m_dcs, m_pdf, a_div, a_dcs, a_pdf;
  int m_pwr[2], m_pat[2], a_pwr[2], a_pat[2];
  always #5 clk = ~clk;
  // identity values are arbitrary, kept apart from the defaults
  asr_bank #(.PART_ID(8'h3c), .SPEED_ID(2'h1)) DUT (.clk(clk), .rst_b(rst_b), .req(req),
    .rdata(rdata), .rvalid(rvalid),
    .lsb_first(lsb_first), .soft_reset(soft_reset), .act_glb(act_glb),
    .act_cha(act_cha), .act_chb(act_chb));
  asr_host_model host (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  // ****************************************
  // model and checks
  // ****************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // shadows and select only; actives survive a soft reset
  task automatic mreset();
    m_sel = 3; m_div = 0; m_dcs = 1; m_pdf = 0;
    m_pwr = '{0, 0}; m_pat = '{0, 0};
  endtask
  task automatic mwr(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h00: begin lsb = d[6] | d[1]; if (d[5] | d[2]) mreset(); end
      8'h05: m_sel = d & 3;
      8'h08: begin m_pdf = d[5]; for (int c = 0; c < 2; c++) if (m_sel[c]) m_pwr[c] = d & 3; end
      8'h09: m_dcs = d[0];
      8'h0b: m_div = d & 7;
      8'h0d: for (int c = 0; c < 2; c++) if (m_sel[c]) m_pat[c] = d & 8'h37;
      default: ;
    endcase
  endtask
  function automatic logic [7:0] mrd(input logic [7:0] a);
    int c;
    c = m_sel[0] ? 0 : 1; // channel A wins when both set
    case (a)
      8'h00: return lsb ? 8'h5a : 8'h18;
      8'h01: return 8'h3c;
      8'h02: return 8'h10;
      8'h05: return 8'(m_sel);
      8'h08: return 8'((m_pdf << 5) | m_pwr[c]);
      8'h09: return 8'(m_dcs);
      8'h0b: return 8'(m_div);
      8'h0d: return 8'(m_pat[c]);
      default: return 8'h00;
    endcase
  endfunction
  task automatic wrc(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d);
    mwr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk({7'h0, v}, 8'h01);
    chk(d, mrd(a));
  endtask
  task automatic act_chk();
    chk({3'h0, act_glb}, 8'({a_pdf[0], a_dcs[0], a_div[2:0]}));
    chk(act_cha, 8'({a_pwr[0][1:0], a_pat[0][5:0]}));
    chk(act_chb, 8'({a_pwr[1][1:0], a_pat[1][5:0]}));
  endtask
  // actives load two edges after the commit write, then the bit reads 0
  task automatic do_commit();
    act_chk();
    host.commit();
    a_div = m_div; a_dcs = m_dcs; a_pdf = m_pdf; a_pwr = m_pwr; a_pat = m_pat;
    repeat (2) @(posedge clk);
    #1 act_chk();
    rdc(8'hff);
  endtask
  task automatic wrap_up();
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    #200000 err_count++;
    wrap_up();
  end
  initial begin
    mreset(); lsb = 0;
    a_div = 0; a_dcs = 1; a_pdf = 0; a_pwr = m_pwr; a_pat = m_pat;
    repeat (3) @(posedge clk);
    #1 rst_b = 1'b1;
    act_chk();
    for (int i = 0; i < 16; i++) rdc(8'(i));
    rdc(8'hff);
    wrc(8'h0b, 8'h03); wrc(8'h08, 8'h21); wrc(8'h0d, 8'h05); rdc(8'h0b);
    do_commit();
    host.sel(8'h01); mwr(8'h05, 8'h01); wrc(8'h0d, 8'h31);
    host.sel(8'h02); mwr(8'h05, 8'h02); wrc(8'h0d, 8'h04); wrc(8'h08, 8'h02);
    rdc(8'h0d); rdc(8'h08); wrc(8'h09, 8'h00);
    host.sel(8'h01); mwr(8'h05, 8'h01); rdc(8'h0d); rdc(8'h09);
    wrc(8'h05, 8'h03); rdc(8'h0d); rdc(8'h08);
    do_commit();
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      wrc(8'h05, (r[1:0] == 2'h0) ? 8'h01 : 8'(r[1:0]));
      wrc(8'h0d, 8'($random(seed))); wrc(8'h08, 8'($random(seed)));
      wrc(8'h0b, 8'($random(seed))); rdc(8'h0d);
      do_commit();
    end
    // no channel selected: local writes go nowhere, globals still land
    wrc(8'h05, 8'h00); wrc(8'h0d, 8'h21); wrc(8'h0b, 8'h06);
    rdc(8'h0d); rdc(8'h0b); rdc(8'h05);
    wrc(8'h05, 8'h03); do_commit();
    wrc(8'h01, 8'hff); wrc(8'h03, 8'hff); rdc(8'h01); rdc(8'h03);
    wrc(8'h00, 8'h00); chk({7'h0, lsb_first}, 8'h00);
    wrc(8'h00, 8'h02); chk({7'h0, lsb_first}, 8'h01); rdc(8'h00);
    wrc(8'h00, 8'h42); chk({7'h0, lsb_first}, 8'h01); rdc(8'h00);
    wrc(8'h00, 8'h04); chk({7'h0, soft_reset}, 8'h01); rdc(8'h0d);
    wrc(8'h00, 8'h66); chk({7'h0, soft_reset}, 8'h01); rdc(8'h05);
    rdc(8'h0d); rdc(8'h0b); rdc(8'h08);
    act_chk();
    wrap_up();
  end
endmodule // tb_adc_spi_shadow_register_bank
